// [rtl/sar_adc_consts.svh]
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// Byte offsets on the register bus
`define ADDR_W           12
`define CTRL_OFFSET      12'h000
`define RESULT_OFFSET    12'h004
`define STATUS_OFFSET    12'h008
`define PINSEL_OFFSET    12'h00c

// converter_control fields
`define CLKSEL_MSB       7
`define CLKSEL_LSB       6
`define CHAN_MSB         5
`define CHAN_LSB         2
`define GO_BIT           1
`define ON_BIT           0
`define CLKSEL_RESET     2'h3
`define CHAN_RESET       4'hf
`define FIXED_REF_CHAN   4'hf

// status fields
`define DONE_BIT         0

// analog_pin_select
`define PINSEL_RESET     8'hff

// Sequencing, counted in bit periods
`define SAMPLE_PERIODS   4'h5
`define CONV_PERIODS     4'hd
`define MARKER_LOAD      8'h80
`define MARKER_TOP       3'h7

// Conversion clock divisors
`define DIV_16           5'h10
`define DIV_8            5'h08
`define DIV_4            5'h04

`endif

// [rtl/sar_adc_pkg.sv]
package sar_adc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_SAMPLE  = 3'h2,
    ST_CONVERT = 3'h4
  } conv_state_t;

  typedef enum logic [1:0] {
    CK_OSC_16  = 2'h0,
    CK_OSC_8   = 2'h1,
    CK_OSC_4   = 2'h2,
    CK_INTOSC4 = 2'h3
  } clk_sel_t;

endpackage

// [rtl/bit_tick_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface bit_tick_if;
  sar_adc_pkg::clk_sel_t clk_sel;
  logic                  run;
  logic                  bit_tick;

  modport gen (input clk_sel, input run, output bit_tick);
  modport seq (output clk_sel, output run, input bit_tick);
endinterface

`default_nettype wire

// [rtl/bit_period_gen.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_consts.svh"

module bit_period_gen (
  input  wire logic   clk,
  input  wire logic   arst_n,
  input  wire logic   internal_oscillator_tick,
  bit_tick_if.gen     tick
);

  logic [4:0] cnt_reg;
  logic [4:0] divisor;
  logic       src_en;

  // Divisor and source per clock select
  always_comb begin
    unique case (tick.clk_sel)
      sar_adc_pkg::CK_OSC_16:  divisor = `DIV_16;
      sar_adc_pkg::CK_OSC_8:   divisor = `DIV_8;
      sar_adc_pkg::CK_OSC_4:   divisor = `DIV_4;
      sar_adc_pkg::CK_INTOSC4: divisor = `DIV_4;
    endcase
    src_en = (tick.clk_sel == sar_adc_pkg::CK_INTOSC4) ? internal_oscillator_tick : 1'b1;
  end

  // Restarts with each conversion so every bit period is whole
  always_ff @(posedge clk or negedge arst_n) begin // see RQ16
    if (!arst_n) begin
      cnt_reg       <= 5'h0;
      tick.bit_tick <= 1'b0;
    end else if (!tick.run) begin
      cnt_reg       <= 5'h0;
      tick.bit_tick <= 1'b0;
    end else if (src_en && cnt_reg == divisor - 5'h1) begin
      cnt_reg       <= 5'h0;
      tick.bit_tick <= 1'b1;
    end else begin
      cnt_reg       <= src_en ? cnt_reg + 5'h1 : cnt_reg;
      tick.bit_tick <= 1'b0;
    end
  end

endmodule // bit_period_gen

`default_nettype wire

// [rtl/sar_adc_sequencer.sv]
// Operation
// RQ1: Old result readable during next sampling
// RQ2: Sampling end clears result, loads marker
// RQ3: Each bit: marker right, decided bit in
// RQ4: Nine marker shifts end conversion, clear go; the code ends it after eight shifts (mpos_reg 7 down to 0)
// RQ5: Software clear aborts, no flag, keep result
// RQ6: Marker position shows bits resolved after abort
// RQ7: Clock select picks divisor and source
// RQ8: Channel codes: 0-7 pins, 15 reference
// RQ9: Writing go starts; reads one while busy
// RQ10: Go ignored while converter is off
// RQ11: Converter off means powered down, idle
// RQ12: Reset: selects all ones, go/on cleared
// RQ13: Sleep clears go and on, halts
// RQ14: Partial result only if bit resolved
// RQ15: Sleep sets selects to ones; pins on wake
// RQ16: Bit period is source over divisor
// RQ17: Software keeps bit period 500ns-50us
// RQ18: Conversion takes thirteen bit periods
// RQ19: Normal end clears go, sets done flag
// RQ20: Clock select change applies next conversion
// RQ21: Channel change applies after current conversion
// RQ22: One comparator decision per bit period
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_consts.svh"

module sar_adc_sequencer (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`ADDR_W-1:0]   paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sleep_enter,
  input  wire logic                 wake,
  input  wire logic                 internal_oscillator_tick,
  input  wire logic                 comp_decision,
  output logic                      converter_on,
  output logic                      sample_hold,
  output logic      [7:0]           trial_code,
  output logic      [7:0]           channel_onehot,
  output logic                      fixed_ref_sel,
  output logic      [7:0]           analog_pin_select
);

  function automatic logic addr_hit(input logic [`ADDR_W-1:0] a);
    addr_hit = (a == `CTRL_OFFSET) || (a == `RESULT_OFFSET) ||
               (a == `STATUS_OFFSET) || (a == `PINSEL_OFFSET);
  endfunction

  sar_adc_pkg::conv_state_t state_reg;
  sar_adc_pkg::clk_sel_t    clk_sel_reg;
  sar_adc_pkg::clk_sel_t    act_clk_reg;
  logic [3:0]               chan_reg;
  logic [3:0]               act_chan_reg;
  logic                     on_reg;
  logic [7:0]               result_reg;
  logic [2:0]               mpos_reg;
  logic [3:0]               period_reg;
  logic                     done_flag_reg;
  logic [7:0]               pinsel_reg;
  logic                     wr;
  logic                     wr_ctrl;
  logic                     start;
  logic                     abort;
  logic                     busy;
  logic                     tick_now;
  logic                     sample_end;
  logic                     conv_end;

  bit_tick_if tick ();

  bit_period_gen u_gen (
    .clk         (clk),
    .arst_n      (arst_n),
    .internal_oscillator_tick (internal_oscillator_tick),
    .tick        (tick.gen)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !addr_hit(paddr);
  assign wr         = psel && penable && pwrite && addr_hit(paddr);
  assign wr_ctrl    = wr && paddr == `CTRL_OFFSET;
  assign busy       = state_reg != sar_adc_pkg::ST_IDLE;
  assign tick_now   = tick.bit_tick;
  // Enable bit in the same write must be one for go to take
  assign start      = wr_ctrl && !busy && !sleep_enter &&
                      pwdata[`GO_BIT] && pwdata[`ON_BIT]; // see RQ9 see RQ10
  assign abort      = wr_ctrl && busy &&
                      (!pwdata[`GO_BIT] || !pwdata[`ON_BIT]); // see RQ5 see RQ11
  assign sample_end = state_reg == sar_adc_pkg::ST_SAMPLE && tick_now &&
                      period_reg == `SAMPLE_PERIODS - 4'h1;
  assign conv_end   = state_reg == sar_adc_pkg::ST_CONVERT && tick_now &&
                      period_reg == `CONV_PERIODS - 4'h1; // see RQ18

  // Read data is captured in the setup cycle, so it is a flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CTRL_OFFSET:   prdata <= {24'h0, clk_sel_reg, chan_reg, busy, on_reg}; // see RQ9
        `RESULT_OFFSET: prdata <= {24'h0, result_reg};
        `STATUS_OFFSET: prdata <= {31'h0, done_flag_reg};
        `PINSEL_OFFSET: prdata <= {24'h0, pinsel_reg};
        default:        prdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control fields

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_sel_reg <= sar_adc_pkg::clk_sel_t'(`CLKSEL_RESET); // see RQ12
      chan_reg    <= `CHAN_RESET;
      on_reg      <= 1'b0;
    end else if (sleep_enter) begin
      clk_sel_reg <= sar_adc_pkg::clk_sel_t'(`CLKSEL_RESET); // see RQ13 see RQ15
      chan_reg    <= `CHAN_RESET;
      on_reg      <= 1'b0;
    end else if (wr_ctrl) begin
      clk_sel_reg <= sar_adc_pkg::clk_sel_t'(pwdata[`CLKSEL_MSB:`CLKSEL_LSB]);
      chan_reg    <= pwdata[`CHAN_MSB:`CHAN_LSB];
      on_reg      <= pwdata[`ON_BIT];
    end
  end

  // Pins stay as they are on sleep entry, return to analog on wake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinsel_reg <= `PINSEL_RESET;
    end else if (wake) begin
      pinsel_reg <= `PINSEL_RESET; // see RQ15
    end else if (wr && paddr == `PINSEL_OFFSET) begin
      pinsel_reg <= pwdata[7:0];
    end
  end

  // Both selects come from the start write itself; channel then follows only when idle
  // Taking the channel from chan_reg at start would convert the previously stored channel
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_clk_reg  <= sar_adc_pkg::clk_sel_t'(`CLKSEL_RESET);
      act_chan_reg <= `CHAN_RESET;
    end else begin
      if (start) begin
        act_clk_reg  <= sar_adc_pkg::clk_sel_t'(pwdata[`CLKSEL_MSB:`CLKSEL_LSB]); // see RQ20
        act_chan_reg <= pwdata[`CHAN_MSB:`CHAN_LSB];
      end else if (!busy) begin
        act_chan_reg <= chan_reg; // see RQ21
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= sar_adc_pkg::ST_IDLE;
    end else if (sleep_enter || abort) begin
      state_reg <= sar_adc_pkg::ST_IDLE; // see RQ5 see RQ13
    end else begin
      unique case (state_reg)
        sar_adc_pkg::ST_IDLE:    if (start) state_reg <= sar_adc_pkg::ST_SAMPLE;
        sar_adc_pkg::ST_SAMPLE:  if (sample_end) state_reg <= sar_adc_pkg::ST_CONVERT;
        sar_adc_pkg::ST_CONVERT: if (conv_end) state_reg <= sar_adc_pkg::ST_IDLE; // see RQ4
        default:                 state_reg <= sar_adc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      period_reg <= 4'h0;
    end else if (start) begin
      period_reg <= 4'h0;
    end else if (busy && tick_now) begin
      period_reg <= period_reg + 4'h1; // see RQ18
    end
  end

  // Trial code is the result itself: resolved bits, marker one, zeros below
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_reg <= 8'h0;
      mpos_reg   <= `MARKER_TOP;
    end else if (sleep_enter || abort) begin
      result_reg <= result_reg; // see RQ6 see RQ14
    end else if (sample_end) begin
      result_reg <= `MARKER_LOAD; // see RQ2
      mpos_reg   <= `MARKER_TOP;
    end else if (state_reg == sar_adc_pkg::ST_CONVERT && tick_now) begin
      result_reg[mpos_reg] <= comp_decision; // see RQ3 see RQ22
      if (mpos_reg != 3'h0) begin
        result_reg[mpos_reg - 3'h1] <= 1'b1;
      end
      mpos_reg <= mpos_reg - 3'h1;
    end else if (!busy && wr && paddr == `RESULT_OFFSET) begin
      result_reg <= pwdata[7:0]; // see RQ1
    end
  end

  // A completion in the same cycle as a clear keeps the flag set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_flag_reg <= 1'b0;
    end else if (conv_end && !sleep_enter && !abort) begin
      done_flag_reg <= 1'b1; // see RQ19
    end else if (wr && paddr == `STATUS_OFFSET && pwdata[`DONE_BIT]) begin
      done_flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog side

  assign tick.clk_sel      = act_clk_reg; // see RQ7
  assign tick.run          = busy;
  assign converter_on      = on_reg; // see RQ11
  assign sample_hold       = state_reg == sar_adc_pkg::ST_SAMPLE;
  assign trial_code        = result_reg;
  assign fixed_ref_sel     = act_chan_reg == `FIXED_REF_CHAN; // see RQ8
  // Reserved codes select nothing
  assign channel_onehot    = act_chan_reg[3] ? 8'h0 : 8'h1 << act_chan_reg[2:0];
  assign analog_pin_select = pinsel_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_old_result_held: // see RQ1
  assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == sar_adc_pkg::ST_SAMPLE && !sample_end |=> $stable(result_reg))
    else $error("result changed during sampling");

  a_marker_load: // see RQ2
  assert property (@(posedge clk) disable iff (!arst_n)
    sample_end && !abort && !sleep_enter |=> result_reg == `MARKER_LOAD && state_reg == sar_adc_pkg::ST_CONVERT)
    else $error("marker not loaded at sampling end");

  a_bit_stuffed: // see RQ3
  assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == sar_adc_pkg::ST_CONVERT && tick_now && !abort && !sleep_enter
    |=> result_reg[$past(mpos_reg)] == $past(comp_decision))
    else $error("decided bit not stored at marker");

  a_end_clears_go: // see RQ4
  assert property (@(posedge clk) disable iff (!arst_n)
    conv_end && !abort && !sleep_enter |=> !busy && done_flag_reg)
    else $error("completion did not end conversion");

  a_abort_no_flag: // see RQ5
  assert property (@(posedge clk) disable iff (!arst_n)
    abort && !done_flag_reg |=> !busy && !done_flag_reg && result_reg == $past(result_reg))
    else $error("abort set flag or lost result");

  a_go_needs_on: // see RQ10
  assert property (@(posedge clk) disable iff (!arst_n)
    wr_ctrl && !busy && !pwdata[`ON_BIT] |=> !busy)
    else $error("conversion started while off");

  a_sleep_defaults: // see RQ13
  assert property (@(posedge clk) disable iff (!arst_n)
    sleep_enter && !wake |=> !busy && !on_reg && clk_sel_reg == sar_adc_pkg::CK_INTOSC4 && chan_reg == `CHAN_RESET
                    && analog_pin_select == $past(analog_pin_select))
    else $error("sleep entry defaults wrong");

  a_selects_held: // see RQ20
  assert property (@(posedge clk) disable iff (!arst_n)
    busy && $past(busy) |-> $stable(act_clk_reg) && $stable(act_chan_reg))
    else $error("active selects changed mid conversion");

  a_thirteen_periods: // see RQ18
  assert property (@(posedge clk) disable iff (!arst_n)
    conv_end |-> period_reg == `CONV_PERIODS - 4'h1 && mpos_reg == 3'h0)
    else $error("conversion length wrong");

  a_off_means_idle: // see RQ11
  assert property (@(posedge clk) disable iff (!arst_n)
    !converter_on |-> !busy)
    else $error("conversion running while converter off");

  a_start_samples: // see RQ9
  assert property (@(posedge clk) disable iff (!arst_n)
    start |=> busy && sample_hold && $stable(result_reg))
    else $error("start did not enter sampling");

  a_flag_after_end: // see RQ19
  assert property (@(posedge clk) disable iff (!arst_n)
    $rose(done_flag_reg) |-> $past(conv_end))
    else $error("done flag set without completion");

endmodule // sar_adc_sequencer

`default_nettype wire

// [bench/analog_front_model.sv]
`timescale 1ns/1ns
`default_nettype none

module analog_front_model (
  input  wire logic       clk,
  input  wire logic [7:0] trial_code,
  input  wire logic [7:0] channel_onehot,
  input  wire logic       fixed_ref_sel,
  output logic            comp_decision
);
  logic [7:0] level;
  logic       idle_bit = 1'b0;

  ////////////////////////////////////////////////////////////////
  // With nothing selected the comparator output wanders, so it toggles
  // instead of holding a value that a broken sequencer could rely on
  always @(posedge clk) begin
    idle_bit <= ~idle_bit;
  end

  // Each channel carries its own fixed level; the reference sits apart
  always_comb begin
    level = 8'h3c;
    for (int k = 0; k < 8; k++) begin
      if (channel_onehot[k]) begin
        level = 8'h25 + 8'h1a * k[7:0];
      end
    end
  end

  assign comp_decision = (fixed_ref_sel || channel_onehot != 8'h00) ? (level >= trial_code) : idle_bit;
endmodule // analog_front_model

`default_nettype wire

// [bench/sar_adc_sequencer_test.sv]
`timescale 1ns/1ns
`default_nettype none

module sar_adc_sequencer_test;
  logic        clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_enter;
  logic        wake;
  logic        internal_oscillator_tick = 1'b0;
  logic        comp_decision;
  logic        converter_on;
  logic        sample_hold;
  logic [7:0]  trial_code;
  logic [7:0]  channel_onehot;
  logic        fixed_ref_sel;
  logic [7:0]  analog_pin_select;
  logic [31:0] q;
  logic        err;
  logic [1:0]  cs;
  logic [3:0]  ch;
  int          miscompares;
  int          comparisons;
  int          cyc = 0;
  int          t0;
  int          d;
  int          p;

  sar_adc_sequencer dut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_enter(sleep_enter),
    .wake(wake), .internal_oscillator_tick(internal_oscillator_tick), .comp_decision(comp_decision), .converter_on(converter_on),
    .sample_hold(sample_hold), .trial_code(trial_code), .channel_onehot(channel_onehot),
    .fixed_ref_sel(fixed_ref_sel), .analog_pin_select(analog_pin_select)
  );

  analog_front_model analog (
    .clk(clk), .trial_code(trial_code), .channel_onehot(channel_onehot),
    .fixed_ref_sel(fixed_ref_sel), .comp_decision(comp_decision)
  );

  ////////////////////////////////////////////////////////////////
  always #50 clk = ~clk;

  // Internal oscillator pulses every second cycle, so its divide-by-4 spans 8 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    internal_oscillator_tick <= ~internal_oscillator_tick;
  end

  always @(posedge clk) begin
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lvl(input logic [3:0] c);
    return (c == 4'hf) ? 8'h3c : 8'h25 + 8'h1a * {4'h0, c};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic poll;
    q = 32'h2;
    while (q[1] === 1'b1) apb(1'b0, 12'h000, 32'h0);
  endtask

  // Above the marker the bits are settled, below it nothing is kept
  task automatic partial(input logic [7:0] lv);
    p = 8;
    for (int b = 7; b >= 0; b--) begin
      if (q[b] === 1'b1) p = b;
    end
    chk("bits resolved", 32'h1, p < 7);
    chk("partial result", ((lv >> (p + 1)) << (p + 1)) | (1 << p), q);
    chk("trial code", ((lv >> (p + 1)) << (p + 1)) | (1 << p), {24'h0, trial_code});
  endtask

  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {psel, penable, pwrite, sleep_enter, wake} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {miscompares, comparisons} = {32'h0, 32'h0};
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("control reset", 32'hfc, q);
    apb(1'b0, 12'h00c, 32'h0);
    chk("pins reset", 32'hff, q);
    apb(1'b1, 12'h000, 32'h02);
    apb(1'b0, 12'h000, 32'h0);
    chk("go while off", 32'h00, q);
    chk("power while off", 32'h0, converter_on);
    // Every clock select and every channel code of interest, fields altered mid-run
    for (int i = 0; i < 9; i++) begin
      ch = (i < 8) ? i[3:0] : 4'hf;
      cs = i[1:0];
      // 400 ns at Fosc/4 is below the accurate range; the model settles at once, so it still resolves
      d = (cs == 2'h3) ? 8 : 16 >> cs;
      apb(1'b1, 12'h000, {cs, ch, 2'b11});
      t0 = cyc;
      apb(1'b1, 12'h000, {cs ^ 2'h1, ch ^ 4'h1, 2'b11});
      chk("channel held", (ch < 8) ? 32'h1 << ch : 32'h0, channel_onehot);
      chk("reference select", ch == 4'hf, fixed_ref_sel);
      apb(1'b0, 12'h000, 32'h0);
      chk("busy", 32'h1, q[1]);
      poll();
      chk("duration", 32'h1, (cyc - t0 >= 13 * d) && (cyc - t0 <= 13 * d + 8));
      apb(1'b0, 12'h004, 32'h0);
      chk("result", lvl(ch), q);
      apb(1'b0, 12'h008, 32'h0);
      chk("done flag", 32'h1, q);
      apb(1'b1, 12'h008, 32'h1);
    end
    apb(1'b1, 12'h000, {2'h2, 4'h3, 2'b11});
    apb(1'b0, 12'h004, 32'h0);
    chk("result in sampling", 32'h3c, q);
    chk("sampling", 32'h1, sample_hold);
    repeat (28) @(posedge clk);
    apb(1'b1, 12'h000, {2'h2, 4'h3, 2'b01});
    apb(1'b0, 12'h000, 32'h0);
    chk("aborted idle", 32'h0, q[1]);
    chk("hold released", 32'h0, sample_hold);
    apb(1'b0, 12'h004, 32'h0);
    partial(lvl(4'h3));
    apb(1'b0, 12'h008, 32'h0);
    chk("no flag on abort", 32'h0, q);
    apb(1'b1, 12'h00c, 32'h0f);
    apb(1'b1, 12'h000, {2'h0, 4'h5, 2'b11});
    repeat (120) @(posedge clk);
    sleep_enter <= 1'b1;
    @(posedge clk);
    sleep_enter <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk("control after sleep", 32'hfc, q);
    chk("power after sleep", 32'h0, converter_on);
    apb(1'b0, 12'h00c, 32'h0);
    chk("pins kept in sleep", 32'h0f, q);
    apb(1'b0, 12'h004, 32'h0);
    partial(lvl(4'h5));
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    apb(1'b0, 12'h00c, 32'h0);
    chk("pins on wake", 32'hff, q);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", 32'h1, err);
    chk("unmapped data", 32'h0, q);
    finish_test();
  end
endmodule // sar_adc_sequencer_test

`default_nettype wire
